// ==== supervisor_pkg.sv ====
// Shared constants and register layout for the converter supervision block.
package supervisor_pkg;
  localparam int NUM_CH = 4;
  localparam int CODE_W = 12;
  localparam logic [11:0] GAIN_RESET = 12'hFFF;
  localparam logic [11:0] OFFSET_RESET = 12'h800;
  localparam logic [11:0] CLEAR_CODE_RESET = 12'h000;
  localparam logic [15:0] WDOG_KEY = 16'h0195;
  localparam logic [7:0] CRC_POLY = 8'h07;
  // Status word bit positions.
  localparam int ST_PEC_ERR = 10;
  localparam int ST_RAMP = 9;
  localparam int ST_OVER_TEMP = 8;
  // AXI4-Lite register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LAST_FRAME = 8'h08;
  localparam logic [7:0] ADDR_CODE_BASE = 8'h10;
  localparam logic [7:0] ADDR_GAIN_BASE = 8'h20;
  localparam logic [7:0] ADDR_OFFSET_BASE = 8'h30;
  localparam logic [7:0] ADDR_CLRCODE_BASE = 8'h40;
  // Control register fields.
  localparam int CTRL_ECHO = 0;
  localparam int CTRL_CRC_EN = 1;
  localparam int CTRL_WD_EN = 2;
  localparam int CTRL_WD_SEL = 3;
  localparam int CTRL_CLR_ALLOW = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Watchdog timeouts in ms and derived cycle counts at 125 MHz.
  localparam longint CLK_HZ = 125000000;
  localparam longint WD_MS_0 = 5;
  localparam longint WD_MS_1 = 10;
  localparam longint WD_MS_2 = 100;
  localparam longint WD_MS_3 = 200;
  localparam logic [31:0] WD_CYC_0 = 32'(WD_MS_0 * CLK_HZ / 1000);
  localparam logic [31:0] WD_CYC_1 = 32'(WD_MS_1 * CLK_HZ / 1000);
  localparam logic [31:0] WD_CYC_2 = 32'(WD_MS_2 * CLK_HZ / 1000);
  localparam logic [31:0] WD_CYC_3 = 32'(WD_MS_3 * CLK_HZ / 1000);
  localparam int FRAME_BITS = 32;
  localparam int PLAIN_BITS = 24;
endpackage

// ==== serial_frame_rx.sv ====
// Serial port front end: samples the host pins, shifts frames and checks CRC.
`timescale 1ns/100ps
module serial_frame_rx
  import supervisor_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk_pin,
  input wire logic frame_sel_n_pin,
  input wire logic serial_in,
  input wire logic [15:0] echo_word,
  input wire logic echo_on,
  output logic frame_done,
  output logic frame_ok,
  output logic frame_bad,
  output logic [23:0] frame_word,
  output logic serial_out
);
  logic [2:0] sclk_sy_reg, sclk_sy_next;
  logic [2:0] fs_sy_reg, fs_sy_next;
  logic [2:0] din_sy_reg, din_sy_next;
  logic sclk_q_reg, sclk_q_next, fs_q_reg, fs_q_next;
  logic [31:0] shift_reg, shift_next;
  logic [5:0] count_reg, count_next;
  logic [15:0] echo_reg, echo_next;
  logic done_reg, done_next, ok_reg, ok_next, bad_reg, bad_next, out_reg, out_next;
  logic [23:0] word_reg, word_next;
  logic sclk_s, fs_s;
  logic [7:0] crc;

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  always_comb begin
    sclk_sy_next = {sclk_sy_reg[1:0], sclk_pin};
    fs_sy_next = {fs_sy_reg[1:0], frame_sel_n_pin};
    din_sy_next = {din_sy_reg[1:0], serial_in};
    // A level counts once the second and third stages agree.
    sclk_s = (sclk_sy_reg[2] == sclk_sy_reg[1]) ? sclk_sy_reg[1] : sclk_q_reg;
    fs_s = (fs_sy_reg[2] == fs_sy_reg[1]) ? fs_sy_reg[1] : fs_q_reg;
    sclk_q_next = sclk_s;
    fs_q_next = fs_s;
    shift_next = shift_reg;
    count_next = count_reg;
    echo_next = echo_reg;
    out_next = out_reg;
    done_next = 1'b0;
    ok_next = 1'b0;
    bad_next = 1'b0;
    word_next = word_reg;
    crc = crc8(shift_reg[31:8]);
    if (fs_q_reg && !fs_s) begin
      count_next = 6'h00;
      echo_next = echo_on ? echo_word : 16'h0000;
      out_next = echo_on & echo_word[15];
    end else if (!fs_s && !sclk_q_reg && sclk_s) begin
      // Data is taken on the rising serial clock edge; the echo moves on the falling one.
      shift_next = {shift_reg[30:0], din_sy_reg[2]};
      if (count_reg != 6'h3F) count_next = count_reg + 6'h01;
    end else if (!fs_s && sclk_q_reg && !sclk_s) begin
      echo_next = {echo_reg[14:0], 1'b0};
      out_next = echo_on & echo_reg[14]; // see R10
    end else if (!fs_q_reg && fs_s) begin
      done_next = 1'b1;
      out_next = 1'b0;
      if (count_reg == 6'(FRAME_BITS)) begin
        word_next = shift_reg[31:8];
        ok_next = (crc == shift_reg[7:0]); // see R18
        bad_next = (crc != shift_reg[7:0]);
      end else begin
        word_next = shift_reg[23:0];
        ok_next = (count_reg == 6'(PLAIN_BITS));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // The serial clock idles high, so its detector starts high and sees no false edge.
      sclk_sy_reg <= 3'h7; fs_sy_reg <= 3'h7; din_sy_reg <= 3'h0;
      sclk_q_reg <= 1'b1; fs_q_reg <= 1'b1; shift_reg <= 32'h0;
      count_reg <= 6'h00; echo_reg <= 16'h0; out_reg <= 1'b0;
      done_reg <= 1'b0; ok_reg <= 1'b0; bad_reg <= 1'b0; word_reg <= 24'h0;
    end else begin
      sclk_sy_reg <= sclk_sy_next; fs_sy_reg <= fs_sy_next; din_sy_reg <= din_sy_next;
      sclk_q_reg <= sclk_q_next; fs_q_reg <= fs_q_next; shift_reg <= shift_next;
      count_reg <= count_next; echo_reg <= echo_next; out_reg <= out_next;
      done_reg <= done_next; ok_reg <= ok_next; bad_reg <= bad_next; word_reg <= word_next;
    end
  end

  assign frame_done = done_reg;
  assign frame_ok = ok_reg;
  assign frame_bad = bad_reg;
  assign frame_word = word_reg;
  assign serial_out = out_reg;

  a_ok_bad_excl: assert property (@(posedge aclk) disable iff (!aresetn)
    !(frame_ok && frame_bad)) else $error("frame both good and bad"); // see R18
  a_echo_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !echo_on && $past(!echo_on) |-> !serial_out) else $error("echo while off"); // see R10
endmodule

// ==== dac_supervisor.sv ====
// Fault, calibration, clear, echo and watchdog logic of the four-channel converter.
//
// Overview of operation
// R1 - Fault pin pulled low open-drain while any fault condition is present.
// R2 - Channel headroom-low indication flags that channel's compliance fault.
// R3 - Over-temperature indication asserts the fault pin.
// R4 - Separate status bits for channel faults, packet error and over-temperature.
// R5 - Stored code equals D*(M+1)/4096 + C - 2048 per channel.
// R6 - One multiplier and adder shared; pending channels calibrated in turn.
// R7 - Gain or offset writes do not update; next data write applies them.
// R8 - Gain resets to 4095, offset to 2048.
// R9 - Host calibrates gain first, then offset.
// R10 - With echo enabled, status word is shifted out during every write frame.
// R11 - Echo off after reset; host clears echo before normal readback.
// R12 - Host ignores CRC bits returned during status echo.
// R13 - Clear rising edge loads allowed channels with their clear code.
// R14 - Channels without clear-allow keep their output regardless of clear.
// R15 - Cleared channels keep clear code until a new data write.
// R16 - Host never asserts clear between readback frames.
// R17 - Host appends CRC-8 x^8+x^2+x+1 making a 32-bit frame.
// R18 - Bad CRC discards the write, sets packet error and fault.
// R19 - Status read clears packet error; fault releases if nothing else remains.
// R20 - Host keeps serial clock idle between read and no-op frames.
// R21 - Watchdog raises alert without key write within 5/10/100/200 ms.
// R22 - Alert is an active-high push-pull output.
// R23 - Status bits: packet error D10, ramp D9, over-temp D8, faults D3-D0.
// R24 - Each key write restarts the watchdog; alert holds until one arrives.
// R25 - Calibration result clamped to 0..4095.
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module dac_supervisor
  import supervisor_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sclk_pin,
  input wire logic frame_sel_n_pin,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic clear_pin,
  input wire logic [3:0] headroom_low,
  input wire logic over_temp,
  input wire logic ramp_active,
  output logic fault_n_o,
  output logic fault_n_oe,
  output logic alert,
  output logic [47:0] channel_codes
);
  import supervisor_pkg::*;

  logic aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rdata_reg, rdata_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [11:0] gain_reg [NUM_CH], gain_next [NUM_CH];
  logic [11:0] offs_reg [NUM_CH], offs_next [NUM_CH];
  logic [11:0] clrc_reg [NUM_CH], clrc_next [NUM_CH];
  logic [11:0] data_reg [NUM_CH], data_next [NUM_CH];
  logic [11:0] code_reg [NUM_CH], code_next [NUM_CH];
  logic [3:0] pend_reg, pend_next;
  logic [23:0] last_reg, last_next;
  logic pec_reg, pec_next;
  logic [2:0] clr_sy_reg, clr_sy_next;
  logic clr_q_reg, clr_q_next;
  logic [31:0] wd_cnt_reg, wd_cnt_next;
  logic alert_reg, alert_next, fault_reg, fault_next;
  logic frame_done, frame_ok, frame_bad, clr_s, key_write, wr_fire, rd_fire;
  logic [23:0] frame_word;
  logic [15:0] status_word;
  logic [1:0] sel;
  logic [31:0] wd_limit;
  logic signed [25:0] calc;

  serial_frame_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .sclk_pin(sclk_pin),
    .frame_sel_n_pin(frame_sel_n_pin),
    .serial_in(serial_in),
    .echo_word(status_word),
    .echo_on(ctrl_reg[CTRL_ECHO]),
    .frame_done(frame_done),
    .frame_ok(frame_ok),
    .frame_bad(frame_bad),
    .frame_word(frame_word),
    .serial_out(serial_out)
  );

  // see R23 see R4 see R2
  assign status_word = {5'h00, pec_reg, ramp_active, over_temp, 4'h0, headroom_low};
  assign wr_fire = aw_reg && w_reg && !b_reg;
  assign rd_fire = s_axi_arvalid && !r_reg;
  // A frame word of 0x195 in its low bits is the watchdog key.
  assign key_write = frame_ok && frame_word[15:0] == WDOG_KEY;

  always_comb begin
    sel = 2'(frame_word[17:16]);
    aw_next = aw_reg; w_next = w_reg; awa_next = awa_reg; wd_next = wd_reg;
    b_next = b_reg && !s_axi_bready; bresp_next = bresp_reg;
    r_next = r_reg && !s_axi_rready; rdata_next = rdata_reg; rresp_next = rresp_reg;
    ctrl_next = ctrl_reg; last_next = last_reg; pend_next = pend_reg;
    pec_next = pec_reg;
    gain_next = gain_reg; offs_next = offs_reg; clrc_next = clrc_reg;
    data_next = data_reg; code_next = code_reg;
    calc = 26'sd0;
    if (s_axi_awvalid && !aw_reg) begin
      aw_next = 1'b1; awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_reg) begin
      w_next = 1'b1; wd_next = s_axi_wdata;
    end
    if (wr_fire) begin
      aw_next = 1'b0; w_next = 1'b0; b_next = 1'b1; bresp_next = RESP_OKAY;
      if (awa_reg == ADDR_CTRL) begin
        ctrl_next = wd_reg;
      end else if (awa_reg[7:4] == ADDR_CODE_BASE[7:4] && awa_reg[1:0] == 2'b00) begin
        data_next[awa_reg[3:2]] = wd_reg[11:0];
        pend_next[awa_reg[3:2]] = 1'b1;
      end else if (awa_reg[7:4] == ADDR_GAIN_BASE[7:4] && awa_reg[1:0] == 2'b00) begin
        gain_next[awa_reg[3:2]] = wd_reg[11:0]; // see R7
      end else if (awa_reg[7:4] == ADDR_OFFSET_BASE[7:4] && awa_reg[1:0] == 2'b00) begin
        offs_next[awa_reg[3:2]] = wd_reg[11:0]; // see R7
      end else if (awa_reg[7:4] == ADDR_CLRCODE_BASE[7:4] && awa_reg[1:0] == 2'b00) begin
        clrc_next[awa_reg[3:2]] = wd_reg[11:0];
      end else begin
        bresp_next = RESP_SLVERR;
      end
    end
    // Good serial frames other than the watchdog key write the data register of the addressed channel.
    if (frame_ok) begin
      last_next = frame_word;
      if (!key_write) begin
        data_next[sel] = frame_word[11:0];
        pend_next[sel] = 1'b1;
      end
    end
    if (rd_fire) begin
      r_next = 1'b1; rresp_next = RESP_OKAY; rdata_next = 32'h0;
      if (s_axi_araddr == ADDR_CTRL) rdata_next = ctrl_reg;
      else if (s_axi_araddr == ADDR_STATUS) begin
        rdata_next = {16'h0, status_word};
        pec_next = 1'b0; // see R19
      end else if (s_axi_araddr == ADDR_LAST_FRAME) rdata_next = {8'h0, last_reg};
      else if (s_axi_araddr[7:4] == ADDR_CODE_BASE[7:4])
        rdata_next = {20'h0, code_reg[s_axi_araddr[3:2]]};
      else if (s_axi_araddr[7:4] == ADDR_GAIN_BASE[7:4])
        rdata_next = {20'h0, gain_reg[s_axi_araddr[3:2]]};
      else if (s_axi_araddr[7:4] == ADDR_OFFSET_BASE[7:4])
        rdata_next = {20'h0, offs_reg[s_axi_araddr[3:2]]};
      else if (s_axi_araddr[7:4] == ADDR_CLRCODE_BASE[7:4])
        rdata_next = {20'h0, clrc_reg[s_axi_araddr[3:2]]};
      else rresp_next = RESP_SLVERR;
    end
    if (frame_bad) pec_next = 1'b1; // see R18
    // One shared multiply-add serves the lowest pending channel per cycle.
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend_reg[i]) sel = 2'(i); // see R6
    end
    if (pend_reg != 4'h0) begin
      calc = 26'(($signed({14'h0, data_reg[sel]}) * $signed({13'h0, gain_reg[sel]} + 26'sd1))
             >>> 12) + 26'($signed({14'h0, offs_reg[sel]})) - 26'sd2048; // see R5
      if (calc < 0) code_next[sel] = 12'h000; // see R25
      else if (calc > 26'sd4095) code_next[sel] = 12'hFFF;
      else code_next[sel] = calc[11:0];
      pend_next[sel] = pend_next[sel] & ~(pend_reg[sel] && !(frame_ok || wr_fire));
    end
    if (clr_s && !clr_q_reg) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ctrl_reg[CTRL_CLR_ALLOW + i]) begin // see R13 see R14
          code_next[i] = clrc_reg[i]; // see R15
          pend_next[i] = 1'b0;
        end
      end
    end
  end

  always_comb begin
    clr_sy_next = {clr_sy_reg[1:0], clear_pin};
    clr_s = (clr_sy_reg[2] == clr_sy_reg[1]) ? clr_sy_reg[1] : clr_q_reg;
    clr_q_next = clr_s;
    unique case (ctrl_reg[CTRL_WD_SEL +: 2])
      2'd0: wd_limit = WD_CYC_0;
      2'd1: wd_limit = WD_CYC_1;
      2'd2: wd_limit = WD_CYC_2;
      2'd3: wd_limit = WD_CYC_3;
    endcase
    wd_cnt_next = wd_cnt_reg;
    alert_next = alert_reg;
    if (!ctrl_reg[CTRL_WD_EN] || key_write) begin
      wd_cnt_next = 32'h0; // see R24
      alert_next = 1'b0;
    end else if (wd_cnt_reg >= wd_limit - 32'h1) begin
      alert_next = 1'b1; // see R21
    end else begin
      wd_cnt_next = wd_cnt_reg + 32'h1;
    end
    fault_next = (headroom_low != 4'h0) || over_temp || pec_next; // see R1 see R2 see R3
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'b0; w_reg <= 1'b0; b_reg <= 1'b0; r_reg <= 1'b0;
      awa_reg <= 8'h00; wd_reg <= 32'h0; rdata_reg <= 32'h0;
      bresp_reg <= RESP_OKAY; rresp_reg <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET; // see R11
      last_reg <= 24'h0; pend_reg <= 4'h0; pec_reg <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        gain_reg[i] <= GAIN_RESET; // see R8
        offs_reg[i] <= OFFSET_RESET;
        clrc_reg[i] <= CLEAR_CODE_RESET;
        data_reg[i] <= 12'h000;
        code_reg[i] <= 12'h000;
      end
      clr_sy_reg <= 3'h0; clr_q_reg <= 1'b0; wd_cnt_reg <= 32'h0;
      alert_reg <= 1'b0; fault_reg <= 1'b0;
    end else begin
      aw_reg <= aw_next; w_reg <= w_next; b_reg <= b_next; r_reg <= r_next;
      awa_reg <= awa_next; wd_reg <= wd_next; rdata_reg <= rdata_next;
      bresp_reg <= bresp_next; rresp_reg <= rresp_next;
      ctrl_reg <= ctrl_next; last_reg <= last_next; pend_reg <= pend_next;
      pec_reg <= pec_next;
      gain_reg <= gain_next; offs_reg <= offs_next; clrc_reg <= clrc_next;
      data_reg <= data_next; code_reg <= code_next;
      clr_sy_reg <= clr_sy_next; clr_q_reg <= clr_q_next; wd_cnt_reg <= wd_cnt_next;
      alert_reg <= alert_next; fault_reg <= fault_next;
    end
  end

  assign s_axi_awready = !aw_reg;
  assign s_axi_wready = !w_reg;
  assign s_axi_bvalid = b_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !r_reg;
  assign s_axi_rvalid = r_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign fault_n_o = 1'b0;
  assign fault_n_oe = fault_reg; // see R1
  assign alert = alert_reg; // see R22
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_codes
      assign channel_codes[12*g +: 12] = code_reg[g];
    end
  endgenerate

  sequence s_bad_frame;
    frame_bad;
  endsequence
  a_pec_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    s_bad_frame |=> pec_reg && fault_n_oe)
    else $error("bad frame did not set error and fault"); // see R18
  a_fault_temp: assert property (@(posedge aclk) disable iff (!aresetn)
    over_temp |=> fault_n_oe) else $error("over temp without fault"); // see R3
  a_fault_comp: assert property (@(posedge aclk) disable iff (!aresetn)
    headroom_low != 4'h0 |=> fault_n_oe) else $error("headroom without fault"); // see R1
  a_no_fault: assert property (@(posedge aclk) disable iff (!aresetn)
    headroom_low == 4'h0 && !over_temp && !pec_next |=> !fault_n_oe)
    else $error("fault without cause"); // see R19
  a_key_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    key_write |=> !alert ##1 !alert) else $error("alert after key"); // see R24
  a_wd_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_reg[CTRL_WD_EN] |=> !alert) else $error("alert while disabled"); // see R21
  a_clamp_code: assert property (@(posedge aclk) disable iff (!aresetn)
    pend_reg != 4'h0 && calc < 0 && !(clr_s && !clr_q_reg) |=> code_reg[$past(sel)] == 12'h000)
    else $error("negative code not clamped"); // see R25
  a_status_map: assert property (@(posedge aclk) disable iff (!aresetn)
    status_word[ST_OVER_TEMP] == over_temp && status_word[ST_PEC_ERR] == pec_reg)
    else $error("status layout wrong"); // see R23
  a_gain_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    pend_reg == 4'h0 && !(clr_s && !clr_q_reg) |=> $stable(code_reg[0]))
    else $error("code changed without data write"); // see R7
endmodule

// ==== host_serial_model.sv ====
// Behavioural host that drives the four-wire serial port of the supervision block.
`timescale 1ns/100ps
module host_serial_model (
  output logic sclk_pin,
  output logic frame_sel_n_pin,
  output logic serial_in,
  input wire logic serial_out,
  output logic [31:0] echo_bits
);
  initial begin
    sclk_pin = 1'b1;
    frame_sel_n_pin = 1'b1;
    serial_in = 1'b0;
    echo_bits = 32'h0000_0000;
  end

  // The checksum is worked out here on its own, so a wrong polynomial in the block shows up.
  function automatic logic [7:0] crc8(input logic [23:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // The serial clock idles high and stands still between frames, so no edge falls
  // between a command and the frame that follows it.
  task automatic send_frame(input logic [23:0] w, input logic with_crc, input logic bad);
    logic [31:0] bits;
    int n;
    bits = {w, crc8(w) ^ {7'h00, bad}};
    n = with_crc ? 32 : 24;
    echo_bits = 32'h0000_0000;
    frame_sel_n_pin = 1'b0;
    #80;
    for (int i = 31; i > 31 - n; i--) begin
      serial_in = bits[i];
      #40;
      // The block moves its echo bit on the falling edge, so it is read just before it.
      echo_bits = {echo_bits[30:0], serial_out};
      sclk_pin = 1'b0;
      #80;
      sclk_pin = 1'b1;
      #40;
    end
    #80;
    frame_sel_n_pin = 1'b1;
    // A released data line must not keep showing the last bit.
    serial_in = ~serial_in;
    #400;
  endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the converter supervision block.
`timescale 1ns/100ps
module testbench;
  import supervisor_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic sclk_pin, frame_sel_n_pin, serial_in, serial_out;
  logic clear_pin = 1'b0, over_temp = 1'b0, ramp_active = 1'b0;
  logic [3:0] headroom_low = 4'h0;
  logic fault_n_o, fault_n_oe, alert;
  logic [47:0] channel_codes;
  logic [31:0] rdv;
  logic [31:0] echo_bits;
  logic [11:0] gm [4] = '{12'h7FF, 12'hFFF, 12'hFFF, 12'h0FF};
  logic [11:0] off [4] = '{12'h900, 12'hFFF, 12'h000, 12'h800};
  logic [11:0] dd [4] = '{12'h800, 12'hFFF, 12'h000, 12'hABC};
  logic [5:0] stim [3] = '{6'b000100, 6'b010000, 6'b100000};
  logic fexp [3] = '{1'b1, 1'b1, 1'b0};
  logic [31:0] sexp [3] = '{32'h0000_0004, 32'h0000_0100, 32'h0000_0200};
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;

  dac_supervisor i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sclk_pin(sclk_pin), .frame_sel_n_pin(frame_sel_n_pin), .serial_in(serial_in),
    .serial_out(serial_out), .clear_pin(clear_pin), .headroom_low(headroom_low),
    .over_temp(over_temp), .ramp_active(ramp_active), .fault_n_o(fault_n_o),
    .fault_n_oe(fault_n_oe), .alert(alert), .channel_codes(channel_codes)
  );

  host_serial_model i_host (
    .sclk_pin(sclk_pin), .frame_sel_n_pin(frame_sel_n_pin), .serial_in(serial_in),
    .serial_out(serial_out), .echo_bits(echo_bits)
  );

  always #4 aclk = ~aclk;

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, rdv, rsp);
    check(48'(rdv & m), 48'(e));
  endtask

  function automatic logic [11:0] cal(input logic [11:0] d, input logic [11:0] m,
                                      input logic [11:0] c);
    int v;
    v = (int'(d) * (int'(m) + 1)) / 4096 + int'(c) - 2048;
    return v < 0 ? 12'h000 : (v > 4095 ? 12'hFFF : 12'(v));
  endfunction

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
    for (int ch = 0; ch < 4; ch++) begin
      rdchk(ADDR_GAIN_BASE + 8'(4 * ch), 32'h0000_0FFF, 32'(GAIN_RESET));
      rdchk(ADDR_OFFSET_BASE + 8'(4 * ch), 32'h0000_0FFF, 32'(OFFSET_RESET));
    end
    rd(8'hFC, rdv, rsp);
    check(48'({rdv, rsp}), 48'(RESP_SLVERR));
    wr(8'hFC, 32'h0000_0001, rsp);
    check(48'(rsp), 48'(RESP_SLVERR));
    for (int ch = 0; ch < 4; ch++) wr(ADDR_GAIN_BASE + 8'(4 * ch), 32'(gm[ch]), rsp);
    for (int ch = 0; ch < 4; ch++) wr(ADDR_OFFSET_BASE + 8'(4 * ch), 32'(off[ch]), rsp);
    repeat (8) @(posedge aclk);
    check(channel_codes, 48'h0);
    // Four data writes in a row; the shared datapath calibrates each channel before the next write arrives.
    for (int ch = 0; ch < 4; ch++) wr(ADDR_CODE_BASE + 8'(4 * ch), 32'(dd[ch]), rsp);
    repeat (8) @(posedge aclk);
    for (int ch = 0; ch < 4; ch++)
      check(48'(channel_codes[12*ch +: 12]), 48'(cal(dd[ch], gm[ch], off[ch])));
    wr(ADDR_CLRCODE_BASE, 32'h0000_0123, rsp);
    wr(ADDR_CLRCODE_BASE + 8'h04, 32'h0000_0456, rsp);
    wr(ADDR_CTRL, 32'h0000_0100, rsp);
    clear_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    check(48'(channel_codes[11:0]), 48'h123);
    check(48'(channel_codes[23:12]), 48'(cal(dd[1], gm[1], off[1])));
    clear_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    check(48'(channel_codes[11:0]), 48'h123);
    wr(ADDR_CODE_BASE, 32'(dd[0]), rsp);
    repeat (8) @(posedge aclk);
    check(48'(channel_codes[11:0]), 48'(cal(dd[0], gm[0], off[0])));
    for (int i = 0; i < 3; i++) begin
      {ramp_active, over_temp, headroom_low} <= stim[i];
      repeat (8) @(posedge aclk);
      check(48'({fault_n_oe, fault_n_o}), 48'({fexp[i], 1'b0}));
      rdchk(ADDR_STATUS, 32'h0000_070F, sexp[i]);
    end
    ramp_active <= 1'b0;
    i_host.send_frame(24'h000195, 1'b1, 1'b0);
    repeat (8) @(posedge aclk);
    check(48'(fault_n_oe), 48'h0);
    rdchk(ADDR_LAST_FRAME, 32'h00FF_FFFF, 32'h0000_0195);
    i_host.send_frame(24'h0301AA, 1'b1, 1'b1);
    repeat (8) @(posedge aclk);
    check(48'(fault_n_oe), 48'h1);
    rdchk(ADDR_LAST_FRAME, 32'h00FF_FFFF, 32'h0000_0195);
    rdchk(ADDR_STATUS, 32'h0000_070F, 32'h0000_0400);
    rdchk(ADDR_STATUS, 32'h0000_070F, 32'h0000_0000);
    check(48'(fault_n_oe), 48'h0);
    // The 5 ms minimum timeout is far beyond the run budget, so only the quiet case is seen.
    wr(ADDR_CTRL, 32'h0000_0004, rsp);
    i_host.send_frame(24'h000195, 1'b0, 1'b0);
    repeat (8) @(posedge aclk);
    check(48'(alert), 48'h0);
    headroom_low <= 4'hA;
    over_temp <= 1'b1;
    wr(ADDR_CTRL, 32'h0000_0001, rsp);
    repeat (8) @(posedge aclk);
    i_host.send_frame(24'h000195, 1'b1, 1'b0);
    // The status word leads the frame; the trailing checksum bits are disregarded.
    check(48'(echo_bits[31:16]), 48'h010A);
    end_sim();
  end
endmodule
